// ===== core/irs_slave_port.sv
// Two-wire slave port giving word access to 16-bit registers via a pointer.
`timescale 1ns/1ps
module irs_slave_port
  import irs_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = irs_pkg::TIMEOUT_CYC
) (
  input  wire logic                       sys_clk_i,
  input  wire logic                       reset_i,
  input  wire logic                       scl_i,
  output logic                            scl_o,
  output logic                            scl_oe_n_o,
  input  wire logic                       sda_i,
  output logic                            sda_o,
  output logic                            sda_oe_n_o,
  input  wire logic                       addr_strap_bit_low_i,
  input  wire logic                       addr_strap_bit_mid_i,
  input  wire logic                       addr_strap_bit_high_i,
  output logic [irs_pkg::PTR_W-1:0]       reg_index_o,
  output logic                            reg_wr_o,
  output irs_pkg::irs_wr_req_t            reg_wr_req_o,
  output logic                            reg_rd_o,
  input  wire logic [irs_pkg::WORD_W-1:0] reg_rdata_i,
  output logic                            hs_mode_o,
  output logic                            busy_o
);

  import irs_pkg::*;

  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  if (TIMEOUT_CYCLES < 1 || TIMEOUT_CYCLES >= (1 << TIMEOUT_W))
  begin : g_bad_timeout
    $error("TIMEOUT_CYCLES does not fit the timeout counter");
  end

  localparam logic [TIMEOUT_W-1:0] TO_LIMIT = TIMEOUT_W'(TIMEOUT_CYCLES - 1);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_WRITE,
    ST_READ,
    ST_WAIT
  } irs_state_t;

  // ****************************************************************
  // Pin sampling
  // ****************************************************************
  logic scl_s;
  logic sda_s;
  logic strap_lo_s;
  logic strap_mid_s;
  logic strap_hi_s;

  // Sampling at 40 MHz leaves several samples per bit even in high-speed mode.
  irs_sync #(.RESET_VAL(1'b1)) u_sync_scl (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .async_i   (scl_i),
    .level_o   (scl_s)
  );

  irs_sync #(.RESET_VAL(1'b1)) u_sync_sda (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .async_i   (sda_i),
    .level_o   (sda_s)
  );

  irs_sync #(.RESET_VAL(1'b0)) u_sync_strap_lo (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .async_i   (addr_strap_bit_low_i),
    .level_o   (strap_lo_s)
  );

  irs_sync #(.RESET_VAL(1'b0)) u_sync_strap_mid (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .async_i   (addr_strap_bit_mid_i),
    .level_o   (strap_mid_s)
  );

  irs_sync #(.RESET_VAL(1'b0)) u_sync_strap_hi (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .async_i   (addr_strap_bit_high_i),
    .level_o   (strap_hi_s)
  );

  // ****************************************************************
  // Bus condition detection
  // ****************************************************************
  logic       scl_prev_q;
  logic       sda_prev_q;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  logic [6:0] own_addr;

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end
    else
    begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  assign scl_rise  = scl_s & ~scl_prev_q;
  assign scl_fall  = ~scl_s & scl_prev_q;
  assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign stop_det  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
  assign own_addr  = SLAVE_ADDR_TABLE[{strap_lo_s, strap_mid_s, strap_hi_s}];

  // ****************************************************************
  // Protocol state
  // ****************************************************************
  irs_state_t           state_q;
  irs_wphase_t          wphase_q;
  logic [3:0]           bit_cnt_q;
  logic [7:0]           rx_shift_q;
  logic [7:0]           tx_shift_q;
  logic                 sda_drive_q;
  logic                 read_dir_q;
  logic                 low_sel_q;
  logic                 mack_q;
  logic [WORD_W-1:0]    frozen_q;
  logic [7:0]           high_hold_q;
  logic [PTR_W-1:0]     pointer_q;
  logic                 hs_mode_q;
  logic                 busy_q;
  logic [TIMEOUT_W-1:0] to_cnt_q;
  logic                 timeout;
  logic                 addr_match;
  logic                 hs_code;
  logic                 load_word;

  assign timeout    = busy_q & (to_cnt_q == TO_LIMIT);
  // A general call or ten-bit header can never equal a strap address.
  assign addr_match = (rx_shift_q[7:1] == own_addr);
  assign hs_code    = (rx_shift_q[HS_CODE_MSB:HS_CODE_LSB] == HS_CODE_PREFIX);
  // The word is fetched again whenever a high byte is about to go out.
  assign load_word  = scl_fall && (bit_cnt_q == BIT_CNT_ACK)
                      && (((state_q == ST_ADDR) && read_dir_q)
                      || ((state_q == ST_READ) && mack_q && low_sel_q));

  // Bus ownership and the stuck-line watchdog.
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i || stop_det || timeout)
    begin
      busy_q <= 1'b0;
    end
    else if (start_det)
    begin
      busy_q <= 1'b1;
    end
  end

  // Counting only inside a transaction keeps an idle, released bus quiet.
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i || !busy_q || (scl_s && sda_s) || start_det)
    begin
      to_cnt_q <= '0;
    end
    else if (!timeout)
    begin
      to_cnt_q <= to_cnt_q + TIMEOUT_W'(1);
    end
  end

  // High-speed settings last across repeated STARTs.
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i || stop_det || timeout)
    begin
      hs_mode_q <= 1'b0;
    end
    else if (scl_fall && (state_q == ST_ADDR) && (bit_cnt_q == BIT_CNT_BYTE) && hs_code)
    begin
      hs_mode_q <= 1'b1;
    end
  end

  // Bit counter and receive shifter, sampled on SCL rising edges.
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i || start_det)
    begin
      bit_cnt_q  <= BIT_CNT_ZERO;
      rx_shift_q <= 8'h00;
      mack_q     <= 1'b0;
    end
    else if (scl_rise && (state_q != ST_IDLE) && (state_q != ST_WAIT))
    begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
      if (bit_cnt_q < BIT_CNT_BYTE)
      begin
        rx_shift_q <= {rx_shift_q[6:0], sda_s};
      end
      else if (state_q == ST_READ)
      begin
        mack_q <= ~sda_s;
      end
    end
    else if (scl_fall && (bit_cnt_q == BIT_CNT_ACK))
    begin
      bit_cnt_q <= BIT_CNT_ZERO;
    end
  end

  // Main sequencer, advancing on SCL falling edges.
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i || stop_det || timeout)
    begin
      state_q    <= ST_IDLE;
      read_dir_q <= 1'b0;
    end
    else if (start_det)
    begin
      state_q <= ST_ADDR;
    end
    else if (scl_fall)
    begin
      case (state_q)
        ST_ADDR:
        begin
          if (bit_cnt_q == BIT_CNT_BYTE)
          begin
            read_dir_q <= rx_shift_q[RW_BIT];
            if (hs_code || !addr_match)
            begin
              state_q <= ST_WAIT;
            end
          end
          else if (bit_cnt_q == BIT_CNT_ACK)
          begin
            state_q <= read_dir_q ? ST_READ : ST_WRITE;
          end
        end
        ST_READ:
        begin
          if ((bit_cnt_q == BIT_CNT_ACK) && !mack_q)
          begin
            state_q <= ST_WAIT;
          end
        end
        default:
        begin
          state_q <= state_q;
        end
      endcase
    end
  end

  // Open-drain data driver: only ever pulls low.
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i || start_det || stop_det || timeout)
    begin
      sda_drive_q <= 1'b0;
    end
    else if (scl_fall)
    begin
      case (state_q)
        ST_ADDR:
        begin
          if (bit_cnt_q == BIT_CNT_BYTE)
          begin
            sda_drive_q <= addr_match && !hs_code;
          end
          else if (bit_cnt_q == BIT_CNT_ACK)
          begin
            sda_drive_q <= read_dir_q && !reg_rdata_i[WORD_W-1];
          end
        end
        ST_WRITE:
        begin
          sda_drive_q <= (bit_cnt_q == BIT_CNT_BYTE);
        end
        ST_READ:
        begin
          if (bit_cnt_q == BIT_CNT_ACK)
          begin
            if (!mack_q)
            begin
              sda_drive_q <= 1'b0;
            end
            else if (low_sel_q)
            begin
              sda_drive_q <= !reg_rdata_i[WORD_W-1];
            end
            else
            begin
              sda_drive_q <= !frozen_q[7];
            end
          end
          else if (bit_cnt_q == BIT_CNT_BYTE)
          begin
            sda_drive_q <= 1'b0;
          end
          else
          begin
            sda_drive_q <= !tx_shift_q[6];
          end
        end
        default:
        begin
          sda_drive_q <= 1'b0;
        end
      endcase
    end
  end

  // Transmit shifter and frozen read word.
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      tx_shift_q <= 8'h00;
      frozen_q   <= WORD_RESET;
      low_sel_q  <= 1'b0;
    end
    else if (load_word)
    begin
      frozen_q   <= reg_rdata_i;
      tx_shift_q <= reg_rdata_i[15:8];
      low_sel_q  <= 1'b0;
    end
    else if (scl_fall && (state_q == ST_READ))
    begin
      if ((bit_cnt_q == BIT_CNT_ACK) && mack_q)
      begin
        tx_shift_q <= frozen_q[7:0];
        low_sel_q  <= 1'b1;
      end
      else if (bit_cnt_q < BIT_CNT_BYTE)
      begin
        tx_shift_q <= {tx_shift_q[6:0], 1'b0};
      end
    end
  end

  // Write phases: pointer, then high byte held, then the whole word.
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      wphase_q     <= IRS_WPH_POINTER;
      pointer_q    <= PTR_RESET;
      high_hold_q  <= 8'h00;
      reg_wr_o     <= 1'b0;
      reg_wr_req_o <= '0;
    end
    else
    begin
      reg_wr_o <= 1'b0;
      if (start_det)
      begin
        wphase_q <= IRS_WPH_POINTER;
      end
      else if (scl_fall && (state_q == ST_WRITE) && (bit_cnt_q == BIT_CNT_BYTE))
      begin
        case (wphase_q)
          IRS_WPH_POINTER:
          begin
            pointer_q <= rx_shift_q;
            wphase_q  <= IRS_WPH_HIGH;
          end
          IRS_WPH_HIGH:
          begin
            high_hold_q <= rx_shift_q;
            wphase_q    <= IRS_WPH_LOW;
          end
          IRS_WPH_LOW:
          begin
            reg_wr_o           <= 1'b1;
            reg_wr_req_o.index <= pointer_q;
            reg_wr_req_o.data  <= {high_hold_q, rx_shift_q};
            wphase_q           <= IRS_WPH_POINTER;
          end
          default:
          begin
            wphase_q <= IRS_WPH_POINTER;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // The port never stretches the clock, so SCL is left released.
  assign scl_o       = 1'b0;
  assign scl_oe_n_o  = 1'b1;
  assign sda_o       = 1'b0;
  assign sda_oe_n_o  = ~sda_drive_q;
  assign reg_index_o = pointer_q;
  assign reg_rd_o    = load_word;
  assign hs_mode_o   = hs_mode_q;
  assign busy_o      = busy_q;

endmodule

// ===== common/irs_pkg.sv
// Shared constants and types of the two-wire register slave port.
package irs_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS   = 25;
  localparam int TIMEOUT_NS      = 32_800_000;
  localparam int TIMEOUT_CYC     = TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int TIMEOUT_W       = 21;

  // ****************************************************************
  // Byte framing
  // ****************************************************************
  localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
  localparam logic [3:0] BIT_CNT_BYTE = 4'h8;
  localparam logic [3:0] BIT_CNT_ACK  = 4'h9;
  localparam logic [4:0] HS_CODE_PREFIX = 5'h01;
  localparam int         HS_CODE_MSB    = 7;
  localparam int         HS_CODE_LSB    = 3;
  localparam int         RW_BIT         = 0;

  // ****************************************************************
  // Register access
  // ****************************************************************
  localparam int          PTR_W        = 8;
  localparam int          WORD_W       = 16;
  localparam logic [7:0]  PTR_RESET    = 8'h00;
  localparam logic [15:0] WORD_RESET   = 16'h0000;

  // Slave address chosen by the straps, index {low, mid, high}.
  localparam logic [6:0] SLAVE_ADDR_TABLE [8] = '{
    7'h61, 7'h2c, 7'h64, 7'h2e, 7'h62, 7'h2d, 7'h65, 7'h2f
  };

  typedef enum logic [1:0] {
    IRS_WPH_POINTER,
    IRS_WPH_HIGH,
    IRS_WPH_LOW
  } irs_wphase_t;

  typedef struct packed {
    logic [PTR_W-1:0]  index;
    logic [WORD_W-1:0] data;
  } irs_wr_req_t;

endpackage

// ===== core/irs_sync.sv
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/1ps
module irs_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic sys_clk_i,
  input  wire logic reset_i,
  input  wire logic async_i,
  output logic      level_o
);

  logic ff1_q;
  logic ff2_q;
  logic ff3_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      ff1_q <= RESET_VAL;
      ff2_q <= RESET_VAL;
      ff3_q <= RESET_VAL;
    end
    else
    begin
      ff1_q <= async_i;
      ff2_q <= ff1_q;
      ff3_q <= ff2_q;
    end
  end

  // A change is taken only once the second and third stages agree.
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      level_o <= RESET_VAL;
    end
    else if (ff2_q == ff3_q)
    begin
      level_o <= ff3_q;
    end
  end

endmodule

// ===== testbench/irs_slave_port_checker.sv
// Port-level assertions for the two-wire register slave port.
`timescale 1ns/1ps
module irs_slave_port_checker
  import irs_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = 2000
) (
  input wire logic                   sys_clk_i,
  input wire logic                   reset_i,
  input wire logic                   scl_i,
  input wire logic                   sda_i,
  input wire logic                   scl_o,
  input wire logic                   scl_oe_n_o,
  input wire logic                   sda_o,
  input wire logic                   sda_oe_n_o,
  input wire logic [irs_pkg::PTR_W-1:0] reg_index_o,
  input wire logic                   reg_wr_o,
  input wire irs_pkg::irs_wr_req_t   reg_wr_req_o,
  input wire logic                   reg_rd_o,
  input wire logic                   hs_mode_o,
  input wire logic                   busy_o
);
  // ****************************************************************
  // Bus low counter
  // ****************************************************************
  // Saturates so that a long stall cannot wrap and hide a missed timeout.
  int low_cnt_q;
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i || (scl_i && sda_i))
      low_cnt_q <= 0;
    else if (low_cnt_q < TIMEOUT_CYCLES + 16)
      low_cnt_q <= low_cnt_q + 1;
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);

  a_scl_never_driven: assert property (scl_oe_n_o && !scl_o)
    else $error("slave drives scl");
  a_sda_pull_only: assert property (!sda_oe_n_o |-> !sda_o)
    else $error("slave drives sda high");
  a_sda_moves_low: assert property ($changed(sda_oe_n_o) |-> !scl_i)
    else $error("slave sda changed while scl high");
  a_idle_released: assert property (!busy_o && !$past(busy_o) |-> sda_oe_n_o)
    else $error("sda held while bus free");
  a_hs_idle_clear: assert property (!busy_o && !$past(busy_o) |-> !hs_mode_o)
    else $error("high-speed mode outside a transaction");
  a_wr_one_pulse: assert property (reg_wr_o |-> busy_o ##1 !reg_wr_o)
    else $error("write strobe longer than one cycle");
  a_wrreq_with_strobe: assert property ($changed(reg_wr_req_o) |-> reg_wr_o)
    else $error("write word changed without strobe");
  a_rd_one_pulse: assert property (reg_rd_o |-> busy_o ##1 !reg_rd_o)
    else $error("read capture longer than one cycle");
  a_ptr_idle_stable: assert property (!busy_o |=> $stable(reg_index_o))
    else $error("pointer moved outside a transaction");
  a_bus_timeout: assert property (low_cnt_q >= TIMEOUT_CYCLES + 10 |-> !busy_o)
    else $error("no timeout after long low bus");
endmodule

bind irs_slave_port irs_slave_port_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_checker (
  .sys_clk_i(sys_clk_i), .reset_i(reset_i), .scl_i(scl_i), .sda_i(sda_i),
  .scl_o(scl_o), .scl_oe_n_o(scl_oe_n_o), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
  .reg_index_o(reg_index_o), .reg_wr_o(reg_wr_o), .reg_wr_req_o(reg_wr_req_o),
  .reg_rd_o(reg_rd_o), .hs_mode_o(hs_mode_o), .busy_o(busy_o));

// ===== testbench/irs_bus_master.sv
// Bus master model driving the two-wire link from the far side.
`timescale 1ns/1ps
module irs_bus_master (
  input  wire logic sys_clk_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  // ****************************************************************
  // Line control
  // ****************************************************************
  // Outputs are open-drain: a one releases the line to its pull-up.
  logic in_frame;
  initial
  begin
    scl_o    = 1'b1;
    sda_o    = 1'b1;
    in_frame = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic start();
    if (in_frame)
    begin
      scl_o = 1'b0;
      tick(1);
      sda_o = 1'b1;
      tick(5);
      scl_o = 1'b1;
      tick(3);
    end
    sda_o = 1'b0;
    tick(3);
    in_frame = 1'b1;
  endtask

  task automatic stop();
    scl_o = 1'b0;
    tick(1);
    sda_o = 1'b0;
    tick(5);
    scl_o = 1'b1;
    tick(3);
    sda_o = 1'b1;
    tick(6);
    in_frame = 1'b0;
  endtask

  // The long low phase leaves the slave time to move SDA before SCL rises.
  task automatic clk_bit(input logic b, output logic r);
    scl_o = 1'b0;
    tick(1);
    sda_o = b;
    tick(5);
    scl_o = 1'b1;
    tick(2);
    r = sda_i;
  endtask

  task automatic tx_byte(input logic [7:0] b, output logic nack);
    logic r;
    for (int i = 7; i >= 0; i--)
      clk_bit(b[i], r);
    clk_bit(1'b1, nack);
  endtask

  task automatic rx_byte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      clk_bit(1'b1, d[i]);
    clk_bit(nack, r);
  endtask

  // Stalls SCL low for n cycles; a stall longer than the timeout makes the slave's timeout act.
  task automatic hold_low(input int n);
    scl_o = 1'b0;
    tick(n);
  endtask

  task automatic idle();
    sda_o = 1'b1;
    tick(2);
    scl_o = 1'b1;
    tick(3);
    in_frame = 1'b0;
  endtask
endmodule

// ===== testbench/irs_slave_port_test.sv
// Self-checking bench for the two-wire register slave port.
`timescale 1ns/1ps
module irs_slave_port_test;
  import irs_pkg::*;
  // ****************************************************************
  // Environment
  // ****************************************************************
  // A short timeout keeps the run brief yet exceeds every SCL low phase except the deliberate timeout stall.
  localparam int TO_CYC = 400;
  logic        sys_clk, reset, m_scl, m_sda, scl_oe_n, scl_d, sda_oe_n, sda_d;
  logic        wr, rd, hs, busy;
  logic [2:0]  strap;
  logic [7:0]  idx;
  logic [15:0] mem [256];
  logic [31:0] seed;
  irs_wr_req_t wreq;
  irs_wr_req_t wq [$];
  int          n_rd, n_errors, n_tests;
  wire         scl_bus = m_scl & (scl_oe_n | scl_d);
  wire         sda_bus = m_sda & (sda_oe_n | sda_d);
  wire  [15:0] rdata   = mem[idx];

  irs_bus_master master (.sys_clk_i(sys_clk), .scl_i(scl_bus), .sda_i(sda_bus),
    .scl_o(m_scl), .sda_o(m_sda));
  irs_slave_port #(.TIMEOUT_CYCLES(TO_CYC)) dut (.sys_clk_i(sys_clk), .reset_i(reset),
    .scl_i(scl_bus), .scl_o(scl_d), .scl_oe_n_o(scl_oe_n), .sda_i(sda_bus), .sda_o(sda_d),
    .sda_oe_n_o(sda_oe_n), .addr_strap_bit_low_i(strap[2]), .addr_strap_bit_mid_i(strap[1]),
    .addr_strap_bit_high_i(strap[0]), .reg_index_o(idx), .reg_wr_o(wr),
    .reg_wr_req_o(wreq), .reg_rd_o(rd), .reg_rdata_i(rdata), .hs_mode_o(hs),
    .busy_o(busy));

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    if (wr === 1'b1)
    begin
      wq.push_back(wreq);
      mem[wreq.index] <= wreq.data;
    end
    if (rd === 1'b1)
      n_rd++;
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [7:0] addr_byte(input logic rw);
    return {SLAVE_ADDR_TABLE[strap], rw};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk_val(input string name, input logic [23:0] exp, input logic [23:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chk_ack(input string name, input logic exp, input logic got);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic send(input logic [7:0] b, input logic exp, input string name);
    logic nack;
    master.tx_byte(b, nack);
    chk_ack(name, exp, nack);
  endtask
  task automatic open_ptr(input logic [7:0] p);
    master.start();
    send(addr_byte(1'b0), 1'b0, "address ack");
    send(p, 1'b0, "pointer ack");
  endtask
  task automatic chk_wr(input logic [7:0] p, input logic [15:0] d);
    irs_wr_req_t w;
    w = 'x;
    if (wq.size() > 0)
      w = wq.pop_front();
    chk_val("written word", {p, d}, w);
  endtask
  task automatic wr_word(input logic [7:0] p, input logic [15:0] d);
    open_ptr(p);
    send(d[15:8], 1'b0, "high byte ack");
    send(d[7:0], 1'b0, "low byte ack");
    master.stop();
    chk_wr(p, d);
  endtask
  task automatic complete_run();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge sys_clk);
    n_errors++;
    $display("[ERR] run length expected finished seen hang");
    complete_run();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    logic [7:0]  p, q, h, l;
    logic [15:0] d, e;
    {n_rd, n_errors, n_tests} = '0;
    seed = 32'h0000000d;
    reset = 1'b1;
    strap = 3'h0;
    for (int i = 0; i < 256; i++)
      mem[i] = 16'(rnd());
    tick(3);
    reset = 1'b0;
    tick(4);
    chk_val("index after reset", 24'h0, 24'(idx));
    for (int i = 0; i < 8; i++)
    begin
      strap = 3'(i);
      tick(8);
      master.start();
      send({SLAVE_ADDR_TABLE[i] ^ 7'h01, 1'b0}, 1'b1, "foreign address");
      master.stop();
      p = 8'(rnd());
      open_ptr(p);
      master.stop();
      chk_val("pointer", 24'(p), 24'(idx));
      chk_val("busy after stop", 24'h0, 24'(busy));
    end
    master.start();
    send(8'h00, 1'b1, "general call");
    master.stop();
    master.start();
    send({5'h1e, 2'(rnd()), 1'b0}, 1'b1, "ten-bit address");
    master.stop();
    $display("test addressing done");
    for (int i = 0; i < 4; i++)
    begin
      p = 8'(rnd());
      q = 8'(rnd());
      d = 16'(rnd());
      e = 16'(rnd());
      wr_word(p, d);
      open_ptr(p);
      send(d[15:8], 1'b0, "high byte ack");
      send(d[7:0], 1'b0, "low byte ack");
      send(q, 1'b0, "second pointer ack");
      send(e[15:8], 1'b0, "second high ack");
      send(e[7:0], 1'b0, "second low ack");
      master.stop();
      chk_wr(p, d);
      chk_wr(q, e);
      chk_val("pointer kept", 24'(q), 24'(idx));
    end
    open_ptr(p);
    send(8'(rnd()), 1'b0, "lone high byte ack");
    master.stop();
    tick(8);
    chk_val("partial word writes", 24'h0, 24'(wq.size()));
    $display("test writes done");
    e = 16'(rnd());
    wr_word(p, d);
    n_rd = 0;
    open_ptr(p);
    master.start();
    send(addr_byte(1'b1), 1'b0, "read address ack");
    master.rx_byte(1'b0, h);
    mem[p] = e;
    master.rx_byte(1'b0, l);
    chk_val("read word", 24'(d), 24'({h, l}));
    master.rx_byte(1'b0, h);
    master.rx_byte(1'b1, l);
    chk_val("reread word", 24'(e), 24'({h, l}));
    master.rx_byte(1'b1, h);
    chk_val("after nack", 24'hff, 24'(h));
    master.stop();
    chk_val("high byte captures", 24'h2, 24'(n_rd));
    $display("test reads done");
    master.start();
    send({5'h01, 3'(rnd())}, 1'b1, "master code");
    chk_val("high-speed set", 24'h1, 24'(hs));
    open_ptr(p);
    chk_val("high-speed kept", 24'h1, 24'(hs));
    master.stop();
    tick(8);
    chk_val("high-speed cleared", 24'h0, 24'(hs));
    $display("test high-speed done");
    d = {1'b0, 15'(rnd())};
    wr_word(p, d);
    open_ptr(p);
    master.start();
    send(addr_byte(1'b1), 1'b0, "read address ack");
    master.hold_low(20);
    chk_val("data bit driven", 24'h0, 24'(sda_oe_n));
    master.hold_low(TO_CYC + 40);
    chk_val("released on timeout", 24'h1, 24'(sda_oe_n));
    chk_val("idle on timeout", 24'h0, 24'(busy));
    master.idle();
    wr_word(p, 16'(rnd()));
    $display("test timeout done");
    complete_run();
  end
endmodule
